//--- fault_flag_pkg.sv
// constants for the fault-flag and status register bank
// assumes an 8-bit register port driven by a serial-bus front end elsewhere
package fault_flag_pkg;
  localparam logic [7:0] fault_flags_first_addr = 8'h0b;
  localparam logic [7:0] fault_flags_second_addr = 8'h0c;
  localparam logic [7:0] live_status_first_addr = 8'h0d;
  localparam logic [7:0] reg_reset_value = 8'h00;
  // first fault-flag register bits
  localparam int overtemp_shutdown_bit = 0;
  localparam int supply_short_ground_bit = 1;
  localparam int supply_undervolt_bit = 2;
  // second fault-flag register bits
  localparam int data_pin_overvolt_bit = 1;
  localparam int input_overvolt_bit = 2;
  localparam int thermal_warning_bit = 3;
  localparam int supply_prebias_bit = 5;
  // status register bits
  localparam int supply_applied_bit = 0;
  localparam int supply_safe_bit = 2;
  localparam int legacy_attach_bit = 3;
  localparam int cable_attach_bit = 4;
  localparam logic [7:0] first_defined_mask = 8'h07;
  localparam logic [7:0] second_defined_mask = 8'h2e;
endpackage : fault_flag_pkg

//--- fault_flag_status_bank.sv
// fault-flag and live status register bank of a charging-port controller
// assumes detector levels from other clock domains; register port from the bus front end
// Contract
// - supply undervolt on the negative sense input sets bit 2, cleared by a read only once gone.
// - supply short to ground on the negative sense input sets bit 1, read clears only once gone.
// - die overtemperature sets bit 0, read clears only after the condition resolves.
// - the second fault-flag register is read-only, resets to zero, one means event.
// - a flag asserts the interrupt only when its mask bit is set, but always latches.
// - pre-bias bit 5 sets when cable function is on, no sink attached and supply above safe.
// - thermal warning bit 3 sets at the warning threshold, read clears once it ends.
// - with warning flag set and foldback enabled, advertised current and limit are lowered.
// - input overvolt bit 2 and data-pin overvolt bit 1 latch, read clears only once resolved.
// - first status register is read-only, resets to zero, bits 4, 3, 2 and 0 as defined.
// - supply-safe reads one while the supply is below safe level, only with cable function on.
// - cable attach status follows the live attach state of the configuration pins.
`timescale 1ns/10ps
`default_nettype none
module fault_flag_status_bank
  import fault_flag_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic supply_undervolt_i,
  input wire logic supply_short_ground_i,
  input wire logic overtemp_shutdown_i,
  input wire logic thermal_warning_i,
  input wire logic input_overvolt_i,
  input wire logic data_pin_overvolt_i,
  input wire logic supply_above_safe_i,
  input wire logic cable_attach_i,
  input wire logic legacy_charger_attach_i,
  input wire logic supply_applied_i,
  input wire logic cable_function_en_i,
  input wire logic foldback_en_i,
  input wire logic [7:0] mask_first_i,
  input wire logic [7:0] mask_second_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] rd_data_o,
  output logic irq_o,
  output logic foldback_active_o
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // wr_en_i and wr_data_i are accepted but every register here ignores writes
  localparam int n_in = 11;
  logic [n_in-1:0] raw_in;
  logic [n_in-1:0] sync_a;
  logic [n_in-1:0] sync_b;

  assign raw_in = {supply_undervolt_i, supply_short_ground_i, overtemp_shutdown_i,
                   thermal_warning_i, input_overvolt_i, data_pin_overvolt_i,
                   supply_above_safe_i, cable_attach_i, legacy_charger_attach_i,
                   supply_applied_i, cable_function_en_i};

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  logic uv_s, sht_s, ots_s, warn_s, inov_s, dov_s, above_s, cc_s, bc_s, app_s, ccen_s;
  assign {uv_s, sht_s, ots_s, warn_s, inov_s, dov_s, above_s, cc_s, bc_s, app_s, ccen_s}
    = sync_b;

  // ----------------------------------------
  // condition vectors
  // ----------------------------------------
  logic [7:0] cond_first;
  logic [7:0] cond_second;
  logic [7:0] status_live;

  always_comb
  begin
    cond_first = 8'h00;
    cond_first[supply_undervolt_bit] = uv_s;
    cond_first[supply_short_ground_bit] = sht_s;
    cond_first[overtemp_shutdown_bit] = ots_s;
    cond_second = 8'h00;
    cond_second[supply_prebias_bit] = ccen_s & ~cc_s & above_s;
    cond_second[thermal_warning_bit] = warn_s;
    cond_second[input_overvolt_bit] = inov_s;
    cond_second[data_pin_overvolt_bit] = dov_s;
    status_live = 8'h00;
    status_live[cable_attach_bit] = cc_s;
    status_live[legacy_attach_bit] = bc_s;
    status_live[supply_safe_bit] = ccen_s & ~above_s;
    status_live[supply_applied_bit] = app_s;
  end

  // ----------------------------------------
  // sticky fault flags
  // ----------------------------------------
  logic [7:0] flags_first;
  logic [7:0] flags_second;
  logic rd_first;
  logic rd_second;

  assign rd_first = rd_en_i && (addr_i == fault_flags_first_addr);
  assign rd_second = rd_en_i && (addr_i == fault_flags_second_addr);

  // set wins over the read-clear, so a live condition keeps its flag up
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      flags_first <= reg_reset_value;
    else if (rd_first)
      flags_first <= cond_first & first_defined_mask;
    else
      flags_first <= (flags_first | cond_first) & first_defined_mask;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      flags_second <= reg_reset_value;
    else if (rd_second)
      flags_second <= cond_second & second_defined_mask;
    else
      flags_second <= (flags_second | cond_second) & second_defined_mask;
  end

  // ----------------------------------------
  // read data, interrupt and foldback
  // ----------------------------------------
  // read data is registered, so it shows the value from before the read clears it
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rd_data_o <= reg_reset_value;
    else if (rd_en_i)
    begin
      case (addr_i)
        fault_flags_first_addr: rd_data_o <= flags_first;
        fault_flags_second_addr: rd_data_o <= flags_second;
        live_status_first_addr: rd_data_o <= status_live;
        default: rd_data_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= |((flags_first & mask_first_i) | (flags_second & mask_second_i));
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      foldback_active_o <= 1'b0;
    else
      foldback_active_o <= flags_second[thermal_warning_bit] & foldback_en_i;
  end

endmodule : fault_flag_status_bank
`default_nettype wire

//--- host_reader.sv
// host model: one-cycle reads on the register port
// assumes read data registered one edge after the read edge
`timescale 1ns/10ps
`default_nettype none
module host_reader (
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_en_o = 1'b0,
  output logic [7:0] addr_o = 8'h00
);
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    rd_en_o <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_en_o <= 1'b0;
    // released address flips so a stale value never passes for a read
    addr_o <= ~a;
    #1 d = rd_data_i;
  endtask : rd
endmodule : host_reader
`default_nettype wire

//--- fault_flag_monitor.sv
// checker: read data, interrupt and foldback of the bank
// assumes the bank's top ports only, bound below
`timescale 1ns/10ps
`default_nettype none
module fault_flag_monitor (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic overtemp_shutdown_i,
  input wire logic thermal_warning_i,
  input wire logic supply_undervolt_i,
  input wire logic foldback_en_i,
  input wire logic [7:0] mask_first_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic irq_o,
  input wire logic foldback_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence rd_at(logic [7:0] a);
    rd_en_i && addr_i == a;
  endsequence
  AST_FIRST_RSV: assert property (rd_at(8'h0b) |=> rd_data_o[7:3] == 5'h00)
    else $error("first flag reserved bits set");
  AST_SECOND_RSV: assert property (rd_at(8'h0c) |=> (rd_data_o & 8'hd1) == 8'h00)
    else $error("second flag reserved bits set");
  AST_STATUS_RSV: assert property (rd_at(8'h0d) |=> (rd_data_o & 8'he2) == 8'h00)
    else $error("status reserved bits set");
  AST_UNMAPPED: assert property (rd_en_i && !(addr_i inside {[8'h0b:8'h0d]}) |=>
    rd_data_o == 8'h00) else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!rd_en_i |=> $stable(rd_data_o))
    else $error("read data moved without a read");
  AST_OVERTEMP: assert property (overtemp_shutdown_i[*4] ##0 rd_at(8'h0b) |=> rd_data_o[0])
    else $error("overtemp flag missing");
  AST_WARN: assert property (thermal_warning_i[*4] ##0 rd_at(8'h0c) |=> rd_data_o[3])
    else $error("warning flag missing");
  AST_FOLDBACK: assert property ((thermal_warning_i && foldback_en_i)[*5] |-> foldback_active_o)
    else $error("foldback not active");
  AST_IRQ: assert property ((supply_undervolt_i && mask_first_i[2])[*5] |-> irq_o)
    else $error("unmasked flag gave no interrupt");
endmodule : fault_flag_monitor
bind fault_flag_status_bank fault_flag_monitor MON (.clk_i, .reset_i, .overtemp_shutdown_i,
  .thermal_warning_i, .supply_undervolt_i, .foldback_en_i, .mask_first_i, .rd_en_i, .addr_i,
  .rd_data_o, .irq_o, .foldback_active_o);
`default_nettype wire

//--- tb.sv
// testbench: table of detector levels against the three registers
// assumes the bank, its package and the host read model
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fault_flag_pkg::*;
  logic clk_i = 0, reset_i = 1, wr_en_i = 0, rd_en_i, irq_o, foldback_active_o;
  logic [10:0] cond = 0;
  logic fb_en = 1;
  logic [7:0] addr_i, rd_data_o, d, wr_data_i = 8'hff;
  // {conditions, first flags, second flags, status}
  logic [34:0] rows [4] = '{35'h502050001, 35'h2b1022a00, 35'h04d00041c, 35'h0};
  int mismatches = 0, samples_checked = 0;
  always #2.5 clk_i = ~clk_i;
  fault_flag_status_bank DUT (.clk_i, .reset_i, .supply_undervolt_i(cond[10]),
    .supply_short_ground_i(cond[9]), .overtemp_shutdown_i(cond[8]), .thermal_warning_i(cond[7]),
    .input_overvolt_i(cond[6]), .data_pin_overvolt_i(cond[5]), .supply_above_safe_i(cond[4]),
    .cable_attach_i(cond[3]), .legacy_charger_attach_i(cond[2]), .supply_applied_i(cond[1]),
    .cable_function_en_i(cond[0]), .foldback_en_i(fb_en), .mask_first_i(8'h04),
    .mask_second_i(8'h20), .rd_en_i, .addr_i, .wr_en_i, .wr_data_i, .rd_data_o, .irq_o,
    .foldback_active_o);
  host_reader HOST (.clk_i, .rd_data_i(rd_data_o), .rd_en_o(rd_en_i), .addr_o(addr_i));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin mismatches++; $display("BAD %s expected %h seen %h", n, e, g); end
  endtask : chk
  task rd(input logic [7:0] a, input logic [7:0] e);
    HOST.rd(a, d);
    chk("rd_data_o", e, d);
  endtask : rd
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin #20000; mismatches++; finish_test; end
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 0;
    foreach (rows[i]) begin
      @(posedge clk_i) cond <= rows[i][34:24];
      repeat (6) @(posedge clk_i);
      #1 chk("irq_o", {7'h0, rows[i][18] || rows[i][13]}, {7'h0, irq_o});
      chk("foldback_active_o", {7'h0, rows[i][11]}, {7'h0, foldback_active_o});
      rd(8'h0d, rows[i][7:0]);
      rd(8'h0b, rows[i][23:16]);
      rd(8'h0c, rows[i][15:8]);
      @(posedge clk_i) cond <= 0;
      repeat (4) @(posedge clk_i);
      rd(8'h0b, rows[i][23:16]);
      rd(8'h0c, rows[i][15:8]);
      rd(8'h0b, 8'h00);
      rd(8'h0c, 8'h00);
      $display("row %0d done", i);
    end
    // reset in mid-run with every fault but pre-bias present
    @(posedge clk_i) cond <= 11'h7e0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1;
    @(posedge clk_i) reset_i <= 0;
    rd(8'h0c, 8'h00);
    #1 chk("irq_o", 8'h00, {7'h0, irq_o});
    wr_en_i <= 1;
    rd(8'h0e, 8'h00);
    rd(8'h0c, 8'h0e);
    #1 chk("foldback_active_o", 8'h01, {7'h0, foldback_active_o});
    @(posedge clk_i) fb_en <= 0;
    repeat (2) @(posedge clk_i);
    #1 chk("foldback_active_o", 8'h00, {7'h0, foldback_active_o});
    $display("reset and write test done");
    finish_test;
  end
endmodule : tb
`default_nettype wire
